// ===== src/plm_cfg.svh
`ifndef PLM_CFG_SVH
`define PLM_CFG_SVH

`define PLM_FLAG_W 16
`define PLM_TGT_BIT 12
`define PLM_MST_BIT 11
`define PLM_PCI_TGT_INIT_CLKS 16
`define PLM_PCI_SUBSEQ_CLKS 8
`define PLM_PCI_MST_INIT_CLKS 8
`define PLM_EARLY_CLKS 1
`define PLM_TGT_INIT_THR (`PLM_PCI_TGT_INIT_CLKS + 1 - `PLM_EARLY_CLKS)
`define PLM_SUBSEQ_THR (`PLM_PCI_SUBSEQ_CLKS + 1 - `PLM_EARLY_CLKS)
`define PLM_MST_INIT_THR (`PLM_PCI_MST_INIT_CLKS + 1 - `PLM_EARLY_CLKS)
`define PLM_CNT_W 5

`endif

// ===== src/plm_pkg.sv
package plm_pkg;
    typedef enum logic [1:0] {
        PLM_IDLE = 2'b01,
        PLM_BUSY = 2'b10
    } plm_state_type;
    typedef logic [15:0] plm_flags_type;
endpackage

// ===== src/plm_latency_monitor.sv
`timescale 1ns/100ps
`include "plm_cfg.svh"
module plm_latency_monitor #(
    parameter int CNT_W = `PLM_CNT_W
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic hostArbEn,
    input wire logic extMasterOwn,
    input wire logic memReadCmd,
    input wire logic parErrRespEn,
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic trdy_n,
    input wire logic stop_n,
    input wire logic [31:0] ad,
    input wire logic [3:0] cbe_n,
    input wire logic par,
    input wire plm_pkg::plm_flags_type arbEventMask,
    input wire plm_pkg::plm_flags_type arbFlagClr,
    input wire logic parFlagClr,
    output logic [`PLM_FLAG_W-1:0] arbEventFlags,
    output logic arbIrq,
    output logic perrOut_n,
    output logic perrOe,
    output logic parErrDetected
);
    import plm_pkg::*;

    localparam logic [CNT_W-1:0] CNT_MAX = '1;
    localparam int FLAG_BIT [2] = '{`PLM_TGT_BIT, `PLM_MST_BIT};

    plm_state_type state_r;
    logic [CNT_W-1:0] phaseCnt_r;
    logic firstPhase_r;
    logic tgtSeen_r;
    logic mstSeen_r;
    logic [`PLM_FLAG_W-1:0] flags_r;
    logic irq_r;
    logic [31:0] adCap_r;
    logic [3:0] cbeCap_r;
    logic chkPend_r;
    logic chkGap_r;
    logic perrPend_r;
    logic perrOut_n_r;
    logic perrOe_r;
    logic parFlag_r;
    logic busy;
    logic phaseDone;
    logic tgtEvt;
    logic mstEvt;
    logic parBad;
    logic [1:0] evt;

    // latency threshold for the awaited signal in this data phase
    function automatic logic [CNT_W-1:0] limitFor(input logic first,
                                                  input logic isTgt);
        logic [CNT_W-1:0] lim;
        lim = CNT_W'(`PLM_SUBSEQ_THR);
        if (first && isTgt) begin
            lim = CNT_W'(`PLM_TGT_INIT_THR);
        end else if (first) begin
            lim = CNT_W'(`PLM_MST_INIT_THR);
        end
        return lim;
    endfunction

    assign busy = (state_r == PLM_BUSY);
    assign phaseDone = busy && !irdy_n && (!trdy_n || !stop_n);

    // threshold one clock early, equal to the bus limit
    assign tgtEvt = hostArbEn && busy && !tgtSeen_r
                    && (phaseCnt_r == limitFor(firstPhase_r, 1'b1));
    assign mstEvt = hostArbEn && extMasterOwn && busy && !mstSeen_r
                    && (phaseCnt_r == limitFor(firstPhase_r, 1'b0));
    assign evt = {mstEvt, tgtEvt};

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_r <= PLM_IDLE;
        end else begin
            case (state_r)
                PLM_IDLE: begin
                    if (!frame_n) begin
                        state_r <= PLM_BUSY;
                    end
                end
                PLM_BUSY: begin
                    if (frame_n && irdy_n) begin
                        state_r <= PLM_IDLE;
                    end
                end
                default: begin
                    state_r <= PLM_IDLE;
                end
            endcase
        end
    end

    // restart at FRAME# and at each completed data phase
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            phaseCnt_r <= '0;
            firstPhase_r <= 1'b1;
        end else if (!busy) begin
            phaseCnt_r <= !frame_n ? CNT_W'(1) : '0;
            firstPhase_r <= 1'b1;
        end else if (phaseDone) begin
            phaseCnt_r <= CNT_W'(1);
            firstPhase_r <= 1'b0;
        end else if (phaseCnt_r != CNT_MAX) begin
            phaseCnt_r <= phaseCnt_r + CNT_W'(1);
        end
    end

    // stop watching once the awaited signal is seen
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tgtSeen_r <= 1'b0;
            mstSeen_r <= 1'b0;
        end else if (!busy || phaseDone) begin
            tgtSeen_r <= 1'b0;
            mstSeen_r <= 1'b0;
        end else begin
            if (!trdy_n || !stop_n || tgtEvt) begin
                tgtSeen_r <= 1'b1;
            end
            if (!irdy_n || mstEvt) begin
                mstSeen_r <= 1'b1;
            end
        end
    end

    // sticky timeout flags, set wins over clear
    generate
        for (genvar i = 0; i < `PLM_FLAG_W; i++) begin : g_flag
            if (i == FLAG_BIT[0] || i == FLAG_BIT[1]) begin : g_used
                localparam int E = (i == FLAG_BIT[0]) ? 0 : 1;
                always_ff @(posedge core_clk) begin
                    if (!rst_n) begin
                        flags_r[i] <= 1'b0;
                    end else if (evt[E]) begin
                        flags_r[i] <= 1'b1;
                    end else if (arbFlagClr[i]) begin
                        flags_r[i] <= 1'b0;
                    end
                end
            end else begin : g_zero
                always_ff @(posedge core_clk) begin
                    flags_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // mask bit at 0 blocks the interrupt
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(flags_r & arbEventMask);
        end
    end

    // capture each data phase of our own read for the parity check
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            adCap_r <= '0;
            cbeCap_r <= '0;
            chkPend_r <= 1'b0;
            chkGap_r <= 1'b0;
        end else begin
            adCap_r <= ad;
            cbeCap_r <= cbe_n;
            chkPend_r <= busy && !extMasterOwn && memReadCmd
                         && !irdy_n && !trdy_n;
            // with parity response on, disconnect with data skips the check
            chkGap_r <= parErrRespEn && !stop_n;
        end
    end

    assign parBad = (^{adCap_r, cbeCap_r}) != par;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            perrPend_r <= 1'b0;
            perrOut_n_r <= 1'b1;
            perrOe_r <= 1'b0;
        end else begin
            perrPend_r <= chkPend_r && !chkGap_r && parBad && parErrRespEn;
            perrOut_n_r <= !(chkPend_r && !chkGap_r && parBad
                             && parErrRespEn);
            perrOe_r <= (chkPend_r && !chkGap_r && parBad && parErrRespEn)
                        || perrPend_r;
        end
    end

    // detected status, set wins over clear
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            parFlag_r <= 1'b0;
        end else if (chkPend_r && !chkGap_r && parBad) begin
            parFlag_r <= 1'b1;
        end else if (parFlagClr) begin
            parFlag_r <= 1'b0;
        end
    end

    assign arbEventFlags = flags_r;
    assign arbIrq = irq_r;
    assign perrOut_n = perrOut_n_r;
    assign perrOe = perrOe_r;
    assign parErrDetected = parFlag_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    tgt_flag_set_a: assert property (
        tgtEvt |=> arbEventFlags[`PLM_TGT_BIT])
        else $error("target timeout flag not set");
    mst_flag_set_a: assert property (
        mstEvt |=> arbEventFlags[`PLM_MST_BIT])
        else $error("master timeout flag not set");
    no_early_flag_a: assert property (
        (tgtEvt || mstEvt) |-> phaseCnt_r >= CNT_W'(`PLM_SUBSEQ_THR))
        else $error("timeout flagged too early");
    tgt_first_phase_a: assert property (
        (hostArbEn && busy && firstPhase_r && !tgtSeen_r
         && phaseCnt_r == CNT_W'(`PLM_PCI_TGT_INIT_CLKS))
        |=> arbEventFlags[`PLM_TGT_BIT])
        else $error("first phase target timeout missed");
    tgt_later_phase_a: assert property (
        (hostArbEn && busy && !firstPhase_r && !tgtSeen_r
         && phaseCnt_r == CNT_W'(`PLM_PCI_SUBSEQ_CLKS))
        |=> arbEventFlags[`PLM_TGT_BIT])
        else $error("later phase target timeout missed");
    mst_first_phase_a: assert property (
        (hostArbEn && extMasterOwn && busy && firstPhase_r && !mstSeen_r
         && phaseCnt_r == CNT_W'(`PLM_PCI_MST_INIT_CLKS))
        |=> arbEventFlags[`PLM_MST_BIT])
        else $error("first phase master timeout missed");
    mst_later_phase_a: assert property (
        (hostArbEn && extMasterOwn && busy && !firstPhase_r && !mstSeen_r
         && phaseCnt_r == CNT_W'(`PLM_PCI_SUBSEQ_CLKS))
        |=> arbEventFlags[`PLM_MST_BIT])
        else $error("later phase master timeout missed");
    irq_unmasked_a: assert property (
        (arbEventFlags[`PLM_TGT_BIT] && arbEventMask[`PLM_TGT_BIT])
        |=> arbIrq)
        else $error("unmasked timeout gave no interrupt");
    irq_masked_a: assert property (
        !(|(arbEventFlags & arbEventMask)) |=> !arbIrq)
        else $error("masked timeout raised interrupt");
    gap_no_perr_a: assert property (
        (chkPend_r && chkGap_r && !parFlag_r) |=> !parFlag_r ##0 perrOut_n)
        else $error("parity reported in disconnect phase");
    perr_report_a: assert property (
        (chkPend_r && !chkGap_r && parBad && parErrRespEn)
        |=> (!perrOut_n && perrOe && parErrDetected) ##1 perrOe)
        else $error("parity error not reported");
    cnt_restart_a: assert property (
        phaseDone |=> phaseCnt_r == CNT_W'(1))
        else $error("latency counter did not restart");
    cnt_start_a: assert property (
        (!busy && !frame_n) |=> phaseCnt_r == CNT_W'(1))
        else $error("latency counter did not start");
    tgt_seen_stop_a: assert property (
        (busy && !phaseDone && (!trdy_n || !stop_n)) |=> !tgtEvt)
        else $error("target timeout after its answer");
    state_onehot_a: assert property (
        $onehot(state_r))
        else $error("monitor state not one-hot");
    flags_reserved_a: assert property (
        $countones(arbEventFlags) == int'(arbEventFlags[`PLM_TGT_BIT])
                                     + int'(arbEventFlags[`PLM_MST_BIT]))
        else $error("reserved event flag set");
    tgt_refused_a: assert property (
        (!hostArbEn && !arbEventFlags[`PLM_TGT_BIT])
        |=> !arbEventFlags[`PLM_TGT_BIT])
        else $error("target timeout flagged outside host mode");
    mst_refused_a: assert property (
        (!(hostArbEn && extMasterOwn) && !arbEventFlags[`PLM_MST_BIT])
        |=> !arbEventFlags[`PLM_MST_BIT])
        else $error("master timeout flagged without external master");
    tgt_flag_sticky_a: assert property (
        (arbEventFlags[`PLM_TGT_BIT] && !arbFlagClr[`PLM_TGT_BIT])
        |=> arbEventFlags[`PLM_TGT_BIT])
        else $error("target timeout flag lost");
    mst_flag_clear_a: assert property (
        (arbFlagClr[`PLM_MST_BIT] && !mstEvt)
        |=> !arbEventFlags[`PLM_MST_BIT])
        else $error("master timeout flag not cleared");
    irq_mst_unmasked_a: assert property (
        (arbEventFlags[`PLM_MST_BIT] && arbEventMask[`PLM_MST_BIT])
        |=> arbIrq)
        else $error("unmasked master timeout gave no interrupt");
    tgt_thr_exact_a: assert property (
        tgtEvt |-> phaseCnt_r == (firstPhase_r
                                  ? CNT_W'(`PLM_PCI_TGT_INIT_CLKS)
                                  : CNT_W'(`PLM_PCI_SUBSEQ_CLKS)))
        else $error("target threshold not at the bus limit");
    mst_thr_exact_a: assert property (
        mstEvt |-> phaseCnt_r == (firstPhase_r
                                  ? CNT_W'(`PLM_PCI_MST_INIT_CLKS)
                                  : CNT_W'(`PLM_PCI_SUBSEQ_CLKS)))
        else $error("master threshold not at the bus limit");
    perr_driven_a: assert property (
        !perrOut_n |-> perrOe)
        else $error("PERR# low while not driven");
    perr_per_off_a: assert property (
        (chkPend_r && !parErrRespEn) |=> perrOut_n)
        else $error("PERR# driven with parity response off");
endmodule // plm_latency_monitor

// ===== verification/plm_bus_partner.sv
`timescale 1ns/100ps
module plm_bus_partner (
    input wire logic core_clk,
    input wire logic go,
    input wire logic irdyEarly,
    input wire logic useStop,
    input wire logic badPar,
    input wire logic [4:0] wait1,
    input wire logic [4:0] wait2,
    output logic frame_n,
    output logic irdy_n,
    output logic trdy_n,
    output logic stop_n,
    output logic [31:0] ad,
    output logic [3:0] cbe_n,
    output logic par,
    output logic busy
);
    int cnt = -1;
    int last;
    logic goS;
    logic ph;
    initial begin
        {frame_n, irdy_n, trdy_n, stop_n, par, busy} = 6'h3E;
        ad = 32'h0;
        cbe_n = 4'h0;
    end
    // one or two data phases, wait1 then wait2 clocks apart
    always @(posedge core_clk) begin
        goS = go;
        #1;
        last = (wait2 != 5'h0) ? wait1 + wait2 : wait1;
        cnt = (cnt >= 0) ? cnt + 1 : (goS ? 0 : -1);
        if (cnt > last + 1) begin
            cnt = -1;
        end
        busy = (cnt >= 0);
        ph = (cnt == wait1 || cnt == last);
        // controls are pulled up, so they read high when released
        frame_n = !(cnt >= 0 && cnt < last);
        irdy_n = !((irdyEarly && cnt >= 1 && cnt <= last) || ph);
        trdy_n = !ph;
        stop_n = !(ph && useStop && cnt == last);
        // parity trails its data phase by one clock
        if (cnt == wait1 + 1 || cnt == last + 1) begin
            par = ^{ad, cbe_n} ^ badPar;
        end else begin
            par = !par;
        end
        if (cnt == 0) begin
            ad = 32'h0000_1000;
            cbe_n = 4'h6;
        end else if (ph) begin
            ad = 32'hA5C3_0F1E;
            cbe_n = 4'h0;
        end else begin
            ad = ~ad;
            cbe_n = ~cbe_n;
        end
    end
endmodule // plm_bus_partner

// ===== verification/test_pci_arbiter_latency_monitor.sv
`timescale 1ns/100ps
module test_pci_arbiter_latency_monitor;
    import plm_pkg::*;
    localparam logic [4:0] PTBL [4] = '{5'h17, 5'h1C, 5'h0E, 5'h10};
    logic core_clk = 0, rst_n = 0, hostArbEn = 1, extMasterOwn = 0;
    logic memReadCmd = 1, parErrRespEn = 1, parFlagClr = 0, go = 0;
    logic irdyEarly = 1, useStop = 0, badPar = 0;
    logic [4:0] wait1 = 5'h1, wait2 = 5'h0;
    plm_flags_type arbEventMask = 16'h1800, arbFlagClr = 16'h0;
    logic frame_n, irdy_n, trdy_n, stop_n, par, busy, arbIrq;
    logic perrOut_n, perrOe, parErrDetected;
    logic [31:0] ad;
    logic [3:0] cbe_n;
    logic [15:0] arbEventFlags;
    int miscompares = 0, checked = 0, cycles = 0, perrLow, perrDrv;
    always #2.5 core_clk = ~core_clk;
    plm_latency_monitor uut (.core_clk, .rst_n, .hostArbEn, .extMasterOwn,
        .memReadCmd, .parErrRespEn, .frame_n, .irdy_n, .trdy_n, .stop_n,
        .ad, .cbe_n, .par, .arbEventMask, .arbFlagClr, .parFlagClr,
        .arbEventFlags, .arbIrq, .perrOut_n, .perrOe, .parErrDetected);
    plm_bus_partner farEnd (.core_clk, .go, .irdyEarly, .useStop, .badPar,
        .wait1, .wait2, .frame_n, .irdy_n, .trdy_n, .stop_n, .ad, .cbe_n,
        .par, .busy);
    task automatic tally_and_finish;
        if (miscompares == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            $display("CHECK FAILED at %0t: run timed out", $time);
            tally_and_finish();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic xfer(input logic [4:0] w1, input logic [4:0] w2);
        wait1 = w1;
        wait2 = w2;
        go = 1;
        perrLow = 0;
        perrDrv = 0;
        step(1);
        go = 0;
        repeat (w1 + w2 + 8) begin
            step(1);
            if (perrOut_n === 1'b0 && perrOe === 1'b1) begin
                perrLow++;
            end
            if (perrOe === 1'b1) begin
                perrDrv++;
            end
        end
        // bus back at rest and PERR# released
        chk(16'({busy, perrOe}), 16'h0000);
    endtask
    task automatic clr;
        arbFlagClr = 16'hFFFF;
        parFlagClr = 1;
        step(1);
        arbFlagClr = 16'h0;
        parFlagClr = 0;
        step(2);
    endtask
    task automatic sc_target;
        xfer(5'h0F, 5'h00);
        chk(arbEventFlags, 16'h0000);
        xfer(5'h10, 5'h00);
        chk(arbEventFlags, 16'h1000);
        chk(16'(arbIrq), 16'h0001);
        clr();
        xfer(5'h03, 5'h07);
        chk(arbEventFlags, 16'h0000);
        xfer(5'h03, 5'h08);
        chk(arbEventFlags, 16'h1000);
        clr();
    endtask
    task automatic sc_master;
        extMasterOwn = 1;
        irdyEarly = 0;
        xfer(5'h07, 5'h00);
        chk(16'(arbEventFlags[11]), 16'h0000);
        xfer(5'h08, 5'h00);
        chk(16'(arbEventFlags[11]), 16'h0001);
        clr();
        xfer(5'h03, 5'h07);
        chk(16'(arbEventFlags[11]), 16'h0000);
        xfer(5'h03, 5'h08);
        chk(16'(arbEventFlags[11]), 16'h0001);
        clr();
        extMasterOwn = 0;
        irdyEarly = 1;
    endtask
    task automatic sc_mask_refuse;
        // full-budget target, so its interrupt is masked
        arbEventMask = 16'h0800;
        xfer(5'h10, 5'h00);
        chk(arbEventFlags, 16'h1000);
        chk(16'(arbIrq), 16'h0000);
        arbEventMask = 16'h1800;
        step(2);
        chk(16'(arbIrq), 16'h0001);
        clr();
        hostArbEn = 0;
        xfer(5'h10, 5'h00);
        chk(arbEventFlags, 16'h0000);
        hostArbEn = 1;
    endtask
    task automatic sc_parity;
        for (int i = 0; i < 4; i++) begin
            {parErrRespEn, useStop, badPar} = PTBL[i][4:2];
            xfer(5'h04, 5'h00);
            chk(16'(parErrDetected), 16'(PTBL[i][1]));
            chk(16'(perrLow), 16'(PTBL[i][0]));
            chk(16'(perrDrv), 16'(2 * PTBL[i][0]));
            clr();
        end
    endtask
    initial begin
        step(10);
        chk(16'({arbIrq, perrOe, parErrDetected, perrOut_n}), 16'h0001);
        rst_n = 1;
        step(1);
        sc_target();
        sc_master();
        sc_mask_refuse();
        sc_parity();
        tally_and_finish();
    end
endmodule // test_pci_arbiter_latency_monitor
